// ===== rtl/cesid_pkg.sv
/*
 * Shared constants and carrier types for the condition evaluator and the
 * compact instruction decoder.
 * Assumes a single core clock domain and no register bus.
 */
`default_nettype none

package cesid_pkg;

  // ------------------------------------------------------------------
  // Field mask bit positions
  // ------------------------------------------------------------------
  localparam int MASK_CTRL_BIT = 3;
  localparam int MASK_EXT_BIT = 2;
  localparam int MASK_STAT_BIT = 1;
  localparam int MASK_FLAG_BIT = 0;

  // ------------------------------------------------------------------
  // Condition codes
  // ------------------------------------------------------------------
  localparam logic [3:0] COND_ZERO_SET = 4'h0;
  localparam logic [3:0] COND_ZERO_CLEAR = 4'h1;
  localparam logic [3:0] COND_CARRY_SET = 4'h2;
  localparam logic [3:0] COND_CARRY_CLEAR = 4'h3;
  localparam logic [3:0] COND_NEGATIVE = 4'h4;
  localparam logic [3:0] COND_NONNEGATIVE = 4'h5;
  localparam logic [3:0] COND_OVF_SET = 4'h6;
  localparam logic [3:0] COND_OVF_CLEAR = 4'h7;
  localparam logic [3:0] COND_UNSIGNED_ABOVE = 4'h8;
  localparam logic [3:0] COND_UNSIGNED_LS = 4'h9;
  localparam logic [3:0] COND_SIGNED_AT_LEAST = 4'ha;
  localparam logic [3:0] COND_SIGNED_BELOW = 4'hb;
  localparam logic [3:0] COND_SIGNED_ABOVE = 4'hc;
  localparam logic [3:0] COND_SIGNED_AT_MOST = 4'hd;
  localparam logic [3:0] COND_ALWAYS = 4'he;
  localparam logic [3:0] COND_SWI = 4'hf;

  // ------------------------------------------------------------------
  // Top-bit patterns and field bit positions of the compact formats
  // ------------------------------------------------------------------
  localparam logic [2:0] PAT_IMM_ALU = 3'h1;
  localparam logic [5:0] PAT_HIREG = 6'h11;
  localparam logic [3:0] PAT_LDST_REG = 4'h5;
  localparam logic [2:0] PAT_LDST_IMM = 3'h3;
  localparam logic [3:0] PAT_LDST_HALF = 4'h8;
  localparam logic [3:0] PAT_LDST_SP = 4'h9;
  localparam logic [7:0] PAT_SP_ADJ = 8'hb0;
  localparam logic [3:0] PAT_MULTI = 4'hc;
  localparam logic [3:0] PAT_COND_BR = 4'hd;
  localparam logic [3:0] PAT_LONG_BL = 4'hf;
  localparam int SIGNED_SEL_BIT = 9;
  localparam int BYTE_BIT_IMM = 12;
  localparam int LOAD_BIT = 11;
  localparam int HIGH_HALF_BIT = 11;
  localparam int STACK_SIGN_BIT = 7;

  typedef enum logic [3:0] {
    FMT_OTHER, FMT_IMM_ALU, FMT_HIREG, FMT_LDST_REG, FMT_LDST_SIGNED,
    FMT_LDST_IMM, FMT_LDST_HALF, FMT_LDST_SP, FMT_SP_ADJ, FMT_MULTI,
    FMT_COND_BR, FMT_SWI, FMT_LONG_BL
  } cesid_fmt_e;

  typedef struct packed {
    logic n;
    logic z;
    logic c;
    logic v;
  } cesid_flags_s;

  typedef struct packed {
    logic ctrl;
    logic ext;
    logic stat;
    logic flag;
  } cesid_suffix_s;

  typedef struct packed {
    cesid_fmt_e fmt;
    logic [1:0] op;
    logic load;
    logic byte_sel;
    logic high_dst;
    logic high_src;
    logic [2:0] dst_reg;
    logic [2:0] base_reg_field;
    logic [2:0] index_reg_field;
    logic [10:0] offset;
    logic [7:0] reg_list;
    logic [3:0] cond;
    logic stack_sub;
    logic [6:0] stack_adjust_imm;
  } cesid_insn_s;

endpackage : cesid_pkg

`default_nettype wire

// ===== rtl/cesid_decode.sv
/*
 * Field mask builder, condition evaluator and compact instruction format
 * classifier, all registered once on the core clock.
 * Assumes instruction word, flags and suffix inputs come from core logic
 * in the same clock domain, so no synchronisers are needed.
 */
//
// Overview of operation
// - Control suffix sets mask bit 3; extension suffix sets mask bit 2.
// - Flags suffix sets mask bit 0; status suffix sets mask bit 1.
// - Single-flag conditions test Z, C, N or V set or clear.
// - Unsigned-above passes when C set and Z clear.
// - Signed-below passes when N differs from V.
// - Signed-above passes when Z clear and N equals V.
// - Signed-at-most passes when Z set or N differs from V.
// - Top bits 001 decode immediate move/compare/add/subtract fields.
// - Top bits 010001 decode high-register operation or branch-exchange.
// - Top bits 0101 with bit 9 clear decode register-offset load/store.
// - Top bits 0101 with bit 9 set decode sign-extended load/store.
// - Top bits 011 decode immediate-offset load/store; bit12 byte, bit11 load.
// - Top bits 1000 decode halfword load/store with five-bit offset.
// - Top bits 1001 decode stack-relative load/store with eight-bit offset.
// - Top bits 10110000 decode stack adjust with sign and seven-bit size.
// - Top bits 1100 decode multiple load/store with register list.
// - Top bits 1111 decode long branch half; bit 11 picks high/low.
`timescale 1ns/1ps
`default_nettype none

module cesid_decode (
  input wire logic clock,
  input wire logic rst,
  input wire cesid_pkg::cesid_suffix_s suffix,
  input wire logic [3:0] cond_in,
  input wire cesid_pkg::cesid_flags_s flags,
  input wire logic [15:0] insn,
  output logic [3:0] field_mask,
  output logic cond_pass,
  output var cesid_pkg::cesid_insn_s decoded
);

  // ------------------------------------------------------------------
  // Condition evaluation
  // ------------------------------------------------------------------
  function automatic logic cond_eval(input logic [3:0] cc,
                                     input cesid_pkg::cesid_flags_s f);
    logic r;
    r = 1'b0;
    unique case (cc)
      cesid_pkg::COND_ZERO_SET: r = f.z;
      cesid_pkg::COND_ZERO_CLEAR: r = !f.z;
      cesid_pkg::COND_CARRY_SET: r = f.c;
      cesid_pkg::COND_CARRY_CLEAR: r = !f.c;
      cesid_pkg::COND_NEGATIVE: r = f.n;
      cesid_pkg::COND_NONNEGATIVE: r = !f.n;
      cesid_pkg::COND_OVF_SET: r = f.v;
      cesid_pkg::COND_OVF_CLEAR: r = !f.v;
      cesid_pkg::COND_UNSIGNED_ABOVE: r = f.c && !f.z;
      // Lower-or-same is deliberately left failing; its meaning is unsettled.
      cesid_pkg::COND_UNSIGNED_LS: r = 1'b0;
      cesid_pkg::COND_SIGNED_AT_LEAST: r = (f.n == f.v);
      cesid_pkg::COND_SIGNED_BELOW: r = (f.n != f.v);
      cesid_pkg::COND_SIGNED_ABOVE: r = !f.z && (f.n == f.v);
      cesid_pkg::COND_SIGNED_AT_MOST: r = f.z || (f.n != f.v);
      cesid_pkg::COND_ALWAYS: r = 1'b1;
      cesid_pkg::COND_SWI: r = 1'b0;
    endcase
    return r;
  endfunction : cond_eval

  // ------------------------------------------------------------------
  // Format classification
  // ------------------------------------------------------------------
  cesid_pkg::cesid_insn_s next_decoded;

  always_comb begin
    next_decoded = '0;
    next_decoded.fmt = cesid_pkg::FMT_OTHER;
    next_decoded.dst_reg = insn[2:0];
    next_decoded.base_reg_field = insn[5:3];
    next_decoded.index_reg_field = insn[8:6];
    next_decoded.load = insn[cesid_pkg::LOAD_BIT];
    if (insn[15:13] == cesid_pkg::PAT_IMM_ALU) begin
      next_decoded.fmt = cesid_pkg::FMT_IMM_ALU;
      next_decoded.op = insn[12:11];
      next_decoded.dst_reg = insn[10:8];
      next_decoded.offset = {3'h0, insn[7:0]};
    end else if (insn[15:10] == cesid_pkg::PAT_HIREG) begin
      next_decoded.fmt = cesid_pkg::FMT_HIREG;
      next_decoded.op = insn[9:8];
      next_decoded.high_dst = insn[7];
      next_decoded.high_src = insn[6];
    end else if (insn[15:12] == cesid_pkg::PAT_LDST_REG) begin
      if (insn[cesid_pkg::SIGNED_SEL_BIT]) begin
        // H and S take the places of the load and byte flags.
        next_decoded.fmt = cesid_pkg::FMT_LDST_SIGNED;
      end else begin
        next_decoded.fmt = cesid_pkg::FMT_LDST_REG;
      end
      next_decoded.byte_sel = insn[10];
    end else if (insn[15:13] == cesid_pkg::PAT_LDST_IMM) begin
      next_decoded.fmt = cesid_pkg::FMT_LDST_IMM;
      next_decoded.byte_sel = insn[cesid_pkg::BYTE_BIT_IMM];
      next_decoded.offset = {6'h00, insn[10:6]};
    end else if (insn[15:12] == cesid_pkg::PAT_LDST_HALF) begin
      next_decoded.fmt = cesid_pkg::FMT_LDST_HALF;
      next_decoded.offset = {6'h00, insn[10:6]};
    end else if (insn[15:12] == cesid_pkg::PAT_LDST_SP) begin
      next_decoded.fmt = cesid_pkg::FMT_LDST_SP;
      next_decoded.dst_reg = insn[10:8];
      next_decoded.offset = {3'h0, insn[7:0]};
    end else if (insn[15:8] == cesid_pkg::PAT_SP_ADJ) begin
      next_decoded.fmt = cesid_pkg::FMT_SP_ADJ;
      next_decoded.stack_sub = insn[cesid_pkg::STACK_SIGN_BIT];
      next_decoded.stack_adjust_imm = insn[6:0];
    end else if (insn[15:12] == cesid_pkg::PAT_MULTI) begin
      next_decoded.fmt = cesid_pkg::FMT_MULTI;
      next_decoded.base_reg_field = insn[10:8];
      next_decoded.reg_list = insn[7:0];
    end else if (insn[15:12] == cesid_pkg::PAT_COND_BR) begin
      next_decoded.cond = insn[11:8];
      next_decoded.offset = {3'h0, insn[7:0]};
      if (insn[11:8] == cesid_pkg::COND_SWI) begin
        next_decoded.fmt = cesid_pkg::FMT_SWI;
      end else begin
        next_decoded.fmt = cesid_pkg::FMT_COND_BR;
      end
    end else if (insn[15:12] == cesid_pkg::PAT_LONG_BL) begin
      next_decoded.fmt = cesid_pkg::FMT_LONG_BL;
      next_decoded.load = insn[cesid_pkg::HIGH_HALF_BIT];
      next_decoded.offset = insn[10:0];
    end
  end

  // ------------------------------------------------------------------
  // Output registers
  // ------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      field_mask <= 4'h0;
    end else begin
      field_mask[cesid_pkg::MASK_CTRL_BIT] <= suffix.ctrl;
      field_mask[cesid_pkg::MASK_EXT_BIT] <= suffix.ext;
      field_mask[cesid_pkg::MASK_FLAG_BIT] <= suffix.flag;
      field_mask[cesid_pkg::MASK_STAT_BIT] <= suffix.stat;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cond_pass <= 1'b0;
    end else begin
      cond_pass <= cond_eval(cond_in, flags);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      decoded <= '0;
    end else begin
      decoded <= next_decoded;
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  chk_mask_ctrl: assert property (@(posedge clock) disable iff (rst)
    !$past(rst) |->
    field_mask[cesid_pkg::MASK_CTRL_BIT] == $past(suffix.ctrl) &&
    field_mask[cesid_pkg::MASK_EXT_BIT] == $past(suffix.ext))
    else $error("control or extension mask bit wrong");

  chk_mask_flags: assert property (@(posedge clock) disable iff (rst)
    !$past(rst) |->
    field_mask[cesid_pkg::MASK_FLAG_BIT] == $past(suffix.flag) &&
    field_mask[cesid_pkg::MASK_STAT_BIT] == $past(suffix.stat))
    else $error("flags or status mask bit wrong");

  chk_zero_cond: assert property (@(posedge clock) disable iff (rst)
    cond_in == cesid_pkg::COND_ZERO_SET |=> cond_pass == $past(flags.z))
    else $error("zero-set condition wrong");

  chk_zclear_cond: assert property (@(posedge clock) disable iff (rst)
    cond_in == cesid_pkg::COND_ZERO_CLEAR |=>
    cond_pass == !$past(flags.z))
    else $error("zero-clear condition wrong");

  chk_carry_cond: assert property (@(posedge clock) disable iff (rst)
    cond_in == cesid_pkg::COND_CARRY_SET |=> cond_pass == $past(flags.c))
    else $error("carry-set condition wrong");

  chk_cclear_cond: assert property (@(posedge clock) disable iff (rst)
    cond_in == cesid_pkg::COND_CARRY_CLEAR |=>
    cond_pass == !$past(flags.c))
    else $error("carry-clear condition wrong");

  chk_neg_cond: assert property (@(posedge clock) disable iff (rst)
    cond_in == cesid_pkg::COND_NEGATIVE |=> cond_pass == $past(flags.n))
    else $error("negative condition wrong");

  chk_nonneg_cond: assert property (@(posedge clock) disable iff (rst)
    cond_in == cesid_pkg::COND_NONNEGATIVE |=>
    cond_pass == !$past(flags.n))
    else $error("non-negative condition wrong");

  chk_ovf_cond: assert property (@(posedge clock) disable iff (rst)
    cond_in == cesid_pkg::COND_OVF_SET |=> cond_pass == $past(flags.v))
    else $error("overflow-set condition wrong");

  chk_vclear_cond: assert property (@(posedge clock) disable iff (rst)
    cond_in == cesid_pkg::COND_OVF_CLEAR |=>
    cond_pass == !$past(flags.v))
    else $error("overflow-clear condition wrong");

  chk_above_cond: assert property (@(posedge clock) disable iff (rst)
    cond_in == cesid_pkg::COND_UNSIGNED_ABOVE |=>
    cond_pass == ($past(flags.c) && !$past(flags.z)))
    else $error("unsigned-above condition wrong");

  chk_atleast_cond: assert property (@(posedge clock) disable iff (rst)
    cond_in == cesid_pkg::COND_SIGNED_AT_LEAST |=>
    cond_pass == ($past(flags.n) == $past(flags.v)))
    else $error("signed-at-least condition wrong");

  chk_below_cond: assert property (@(posedge clock) disable iff (rst)
    cond_in == cesid_pkg::COND_SIGNED_BELOW |=>
    cond_pass == ($past(flags.n) != $past(flags.v)))
    else $error("signed-below condition wrong");

  chk_sabove_cond: assert property (@(posedge clock) disable iff (rst)
    cond_in == cesid_pkg::COND_SIGNED_ABOVE |=>
    cond_pass == (!$past(flags.z) && $past(flags.n) == $past(flags.v)))
    else $error("signed-above condition wrong");

  chk_atmost_cond: assert property (@(posedge clock) disable iff (rst)
    cond_in == cesid_pkg::COND_SIGNED_AT_MOST |=>
    cond_pass == ($past(flags.z) || $past(flags.n) != $past(flags.v)))
    else $error("signed-at-most condition wrong");

  chk_imm_fmt: assert property (@(posedge clock) disable iff (rst)
    insn[15:13] == cesid_pkg::PAT_IMM_ALU |=>
    decoded.fmt == cesid_pkg::FMT_IMM_ALU &&
    decoded.op == $past(insn[12:11]) && decoded.dst_reg == $past(insn[10:8])
    && decoded.offset == {3'h0, $past(insn[7:0])})
    else $error("immediate format decode wrong");

  chk_highreg_fmt: assert property (@(posedge clock) disable iff (rst)
    insn[15:10] == cesid_pkg::PAT_HIREG |=>
    decoded.fmt == cesid_pkg::FMT_HIREG && decoded.op == $past(insn[9:8]) &&
    decoded.high_dst == $past(insn[7]) && decoded.high_src == $past(insn[6]))
    else $error("high-register format decode wrong");

  chk_regoff_fmt: assert property (@(posedge clock) disable iff (rst)
    insn[15:12] == cesid_pkg::PAT_LDST_REG &&
    !insn[cesid_pkg::SIGNED_SEL_BIT] |=>
    decoded.fmt == cesid_pkg::FMT_LDST_REG &&
    decoded.index_reg_field == $past(insn[8:6]))
    else $error("register-offset load/store decode wrong");

  chk_signed_fmt: assert property (@(posedge clock) disable iff (rst)
    insn[15:12] == cesid_pkg::PAT_LDST_REG &&
    insn[cesid_pkg::SIGNED_SEL_BIT] |=>
    decoded.fmt == cesid_pkg::FMT_LDST_SIGNED &&
    decoded.load == $past(insn[cesid_pkg::LOAD_BIT]) &&
    decoded.byte_sel == $past(insn[10]))
    else $error("sign-extended load/store decode wrong");

  chk_immoff_fmt: assert property (@(posedge clock) disable iff (rst)
    insn[15:13] == cesid_pkg::PAT_LDST_IMM |=>
    decoded.fmt == cesid_pkg::FMT_LDST_IMM &&
    decoded.byte_sel == $past(insn[cesid_pkg::BYTE_BIT_IMM]) &&
    decoded.offset == {6'h00, $past(insn[10:6])})
    else $error("immediate-offset load/store decode wrong");

  chk_half_fmt: assert property (@(posedge clock) disable iff (rst)
    insn[15:12] == cesid_pkg::PAT_LDST_HALF |=>
    decoded.fmt == cesid_pkg::FMT_LDST_HALF &&
    decoded.load == $past(insn[cesid_pkg::LOAD_BIT]) &&
    decoded.offset == {6'h00, $past(insn[10:6])})
    else $error("halfword load/store decode wrong");

  chk_sprel_fmt: assert property (@(posedge clock) disable iff (rst)
    insn[15:12] == cesid_pkg::PAT_LDST_SP |=>
    decoded.fmt == cesid_pkg::FMT_LDST_SP &&
    decoded.dst_reg == $past(insn[10:8]) &&
    decoded.offset == {3'h0, $past(insn[7:0])})
    else $error("stack-relative load/store decode wrong");

  chk_spadj_fmt: assert property (@(posedge clock) disable iff (rst)
    insn[15:8] == cesid_pkg::PAT_SP_ADJ |=>
    decoded.fmt == cesid_pkg::FMT_SP_ADJ &&
    decoded.stack_sub == $past(insn[cesid_pkg::STACK_SIGN_BIT]) &&
    decoded.stack_adjust_imm == $past(insn[6:0]))
    else $error("stack adjust decode wrong");

  chk_multi_fmt: assert property (@(posedge clock) disable iff (rst)
    insn[15:12] == cesid_pkg::PAT_MULTI |=>
    decoded.fmt == cesid_pkg::FMT_MULTI &&
    decoded.base_reg_field == $past(insn[10:8]) &&
    decoded.reg_list == $past(insn[7:0]))
    else $error("multiple load/store decode wrong");

  chk_longbr_fmt: assert property (@(posedge clock) disable iff (rst)
    insn[15:12] == cesid_pkg::PAT_LONG_BL |=>
    decoded.fmt == cesid_pkg::FMT_LONG_BL &&
    decoded.load == $past(insn[cesid_pkg::HIGH_HALF_BIT]) &&
    decoded.offset == $past(insn[10:0]))
    else $error("long branch half decode wrong");

  chk_condbr_fmt: assert property (@(posedge clock) disable iff (rst)
    insn[15:12] == cesid_pkg::PAT_COND_BR &&
    insn[11:8] != cesid_pkg::COND_SWI |=>
    decoded.fmt == cesid_pkg::FMT_COND_BR)
    else $error("conditional branch decode wrong");

  chk_swi_fmt: assert property (@(posedge clock) disable iff (rst)
    insn[15:12] == cesid_pkg::PAT_COND_BR &&
    insn[11:8] == cesid_pkg::COND_SWI |=>
    decoded.fmt == cesid_pkg::FMT_SWI &&
    decoded.offset == {3'h0, $past(insn[7:0])})
    else $error("software interrupt not taken over branch");

endmodule : cesid_decode

`default_nettype wire

// ===== bench/cesid_core_model.sv
/*
 * Core-side model: presents the status flags to the decoder.
 * Assumes the bench changes the flag bits away from the rising edge.
 */
`timescale 1ns/1ps
`default_nettype none

module cesid_core_model (
  input wire logic [3:0] nzcv,
  output var cesid_pkg::cesid_flags_s flags
);
  assign flags = cesid_pkg::cesid_flags_s'(nzcv);
endmodule : cesid_core_model

`default_nettype wire

// ===== bench/test_cond_eval_short_insn_decode.sv
/*
 * Self-checking bench: reference model with directed and random stimulus.
 * Assumes the package, decoder and core model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module test_cond_eval_short_insn_decode;
  localparam logic [12:0] KTAB [13] = '{13'h08e0, 13'h1090, 13'h13c0,
    13'h0ce0, 13'h0ce0, 13'h0cd0, 13'h08d0, 13'h0890, 13'h0003, 13'h0848,
    13'h0014, 13'h0014, 13'h0810};
  localparam logic [15:0] DIR [16] = '{16'h2000, 16'h1fff, 16'h4400,
    16'h47ff, 16'h5000, 16'h5600, 16'h6000, 16'h7fff, 16'h8000, 16'h9fff,
    16'hb0ff, 16'hb100, 16'hc0ff, 16'hdef0, 16'hdf12, 16'hf800};
  logic clock = 1'b0;
  logic rst = 1'b1;
  cesid_pkg::cesid_suffix_s suffix = '0;
  logic [3:0] cond_in = '0;
  logic [3:0] nzcv = '0;
  logic [15:0] insn = '0;
  cesid_pkg::cesid_flags_s flags;
  logic [3:0] field_mask;
  logic cond_pass;
  cesid_pkg::cesid_insn_s decoded;
  int fails = 0;
  int tests_run = 0;
  bit have = 0;
  logic [31:0] rnd = 32'h000145a0;
  logic [3:0] p_s, p_c, p_f;
  logic [15:0] p_w;

  always #2.5 clock = ~clock;

  cesid_core_model core (.nzcv(nzcv), .flags(flags));
  cesid_decode DUT (.clock(clock), .rst(rst), .suffix(suffix),
    .cond_in(cond_in), .flags(flags), .insn(insn), .field_mask(field_mask),
    .cond_pass(cond_pass), .decoded(decoded));

  // ----------------------------------------------------------------
  // Reference model
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  function automatic bit pass_of(input int c, input int f);
    int n, z, cy, v;
    n = (f / 8) % 2;
    z = (f / 4) % 2;
    cy = (f / 2) % 2;
    v = f % 2;
    case (c)
      0: return z == 1;
      1: return z == 0;
      2: return cy == 1;
      3: return cy == 0;
      4: return n == 1;
      5: return n == 0;
      6: return v == 1;
      7: return v == 0;
      8: return cy == 1 && z == 0;
      10: return n == v;
      11: return n != v;
      12: return z == 0 && n == v;
      13: return z == 1 || n != v;
      14: return 1;
      default: return 0;
    endcase
  endfunction : pass_of

  function automatic void model(input logic [15:0] w,
    output cesid_pkg::cesid_insn_s e, output cesid_pkg::cesid_insn_s m);
    cesid_pkg::cesid_fmt_e f;
    logic [12:0] k;
    if (w[15:13] == 3'h1) f = cesid_pkg::FMT_IMM_ALU;
    else if (w[15:10] == 6'h11) f = cesid_pkg::FMT_HIREG;
    else if (w[15:12] == 4'h5 && !w[9]) f = cesid_pkg::FMT_LDST_REG;
    else if (w[15:12] == 4'h5) f = cesid_pkg::FMT_LDST_SIGNED;
    else if (w[15:13] == 3'h3) f = cesid_pkg::FMT_LDST_IMM;
    else if (w[15:12] == 4'h8) f = cesid_pkg::FMT_LDST_HALF;
    else if (w[15:12] == 4'h9) f = cesid_pkg::FMT_LDST_SP;
    else if (w[15:8] == 8'hb0) f = cesid_pkg::FMT_SP_ADJ;
    else if (w[15:12] == 4'hc) f = cesid_pkg::FMT_MULTI;
    else if (w[15:8] == 8'hdf) f = cesid_pkg::FMT_SWI;
    else if (w[15:12] == 4'hd) f = cesid_pkg::FMT_COND_BR;
    else if (w[15:12] == 4'hf) f = cesid_pkg::FMT_LONG_BL;
    else f = cesid_pkg::FMT_OTHER;
    k = KTAB[f];
    e = '0;
    e.fmt = f;
    e.op = (f == cesid_pkg::FMT_IMM_ALU) ? w[12:11] : w[9:8];
    e.load = w[11];
    e.byte_sel = (f == cesid_pkg::FMT_LDST_IMM) ? w[12] : w[10];
    e.high_dst = w[7];
    e.high_src = w[6];
    e.dst_reg = (f == cesid_pkg::FMT_IMM_ALU || f == cesid_pkg::FMT_LDST_SP)
      ? w[10:8] : w[2:0];
    e.base_reg_field = (f == cesid_pkg::FMT_MULTI) ? w[10:8] : w[5:3];
    e.index_reg_field = w[8:6];
    if (f == cesid_pkg::FMT_LONG_BL) e.offset = w[10:0];
    else if (f == cesid_pkg::FMT_LDST_IMM || f == cesid_pkg::FMT_LDST_HALF)
      e.offset = {6'h00, w[10:6]};
    else e.offset = {3'h0, w[7:0]};
    e.reg_list = w[7:0];
    e.cond = w[11:8];
    e.stack_sub = w[7];
    e.stack_adjust_imm = w[6:0];
    m = {4'hf, {2{k[12]}}, k[11], k[10], k[9], k[8], {3{k[7]}}, {3{k[6]}},
      {3{k[5]}}, {11{k[4]}}, {8{k[3]}}, {4{k[2]}}, k[1], {7{k[0]}}};
  endfunction : model

  // ----------------------------------------------------------------
  // Checks, drivers and closing
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [63:0] exp,
    input logic [63:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask : check

  task automatic compare();
    cesid_pkg::cesid_insn_s e, m;
    model(p_w, e, m);
    check("field_mask", 64'(p_s), 64'(field_mask));
    check("cond_pass", 64'(pass_of(p_c, p_f)), 64'(cond_pass));
    check("decoded", 64'(e & m), 64'(decoded & m));
  endtask : compare

  task automatic cyc(input logic [3:0] s, input logic [3:0] c,
    input logic [3:0] f, input logic [15:0] w);
    @(negedge clock);
    if (have) compare();
    suffix = cesid_pkg::cesid_suffix_s'(s);
    cond_in = c;
    nzcv = f;
    insn = w;
    {p_s, p_c, p_f, p_w} = {s, c, f, w};
    have = 1;
  endtask : cyc

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  initial begin
    repeat (8) @(negedge clock);
    check("reset", 64'h0, {9'h0, field_mask, cond_pass, decoded});
    rst = 1'b0;
    for (int i = 0; i < 256; i++) cyc(i[3:0], i[7:4], i[3:0], DIR[i[3:0]]);
    $display("directed conditions and formats done");
    for (int i = 0; i < 1500; i++) begin
      rnd = lfsr(rnd);
      cyc(rnd[3:0], rnd[7:4], rnd[11:8], rnd[27:12]);
    end
    cyc(4'h0, 4'h0, 4'h0, 16'h0);
    $display("random traffic done");
    @(negedge clock);
    rst = 1'b1;
    have = 0;
    @(negedge clock);
    check("mid reset", 64'h0, {9'h0, field_mask, cond_pass, decoded});
    rst = 1'b0;
    for (int i = 0; i < 16; i++) cyc(4'hf - i[3:0], i[3:0], 4'h5, DIR[i]);
    cyc(4'h0, 4'h0, 4'h0, 16'h0);
    $display("reset in mid-run done");
    end_of_test();
  end

  initial begin
    repeat (5000) @(posedge clock);
    fails++;
    end_of_test();
  end
endmodule : test_cond_eval_short_insn_decode

`default_nettype wire
